// ==== rbir_pkg.sv ====
// package: register map, field layout and encodings of the rate/self-test/id bank
package rbir_pkg;
   // ==========================================================
   // register map (word addresses on the processor port)
   localparam logic [13:0] rate_base_addr = 14'h012d;
   localparam logic [13:0] rate_last_addr = 14'h014c;
   localparam logic [13:0] bist_addr      = 14'h014d;
   localparam logic [13:0] id_addr        = 14'h3fff;
   localparam int          num_streams    = 32;
   localparam int          fast_streams   = 16;
   // ==========================================================
   // field positions
   localparam int rate_lsb      = 0;
   localparam int rate_msb      = 1;
   localparam int bist_en_bit   = 12;
   localparam int start_bp_data = 11;
   localparam int start_lc_data = 8;
   localparam int start_bp_conn = 5;
   localparam int start_lc_conn = 2;
   localparam int rev_lsb       = 4;
   localparam int part_lsb      = 0;
   // ==========================================================
   // reset values and encodings
   localparam logic [15:0] rate_reset = 16'h0000;
   localparam logic [15:0] bist_reset = 16'h0000;
   localparam logic [2:0]  spd_2m     = 3'h0;
   localparam logic [2:0]  spd_4m     = 3'h1;
   localparam logic [2:0]  spd_8m     = 3'h2;
   localparam logic [2:0]  spd_16m    = 3'h3;
   localparam logic [2:0]  spd_32m    = 3'h4;
   localparam logic [2:0]  spd_off    = 3'h7;
   localparam int          test_cycles = 64;
   typedef enum logic [2:0] {
      rbir_idle = 3'b001,
      rbir_run  = 3'b010,
      rbir_done = 3'b100
   } rbir_state_t;
endpackage

// ==== rbir_regs.sv ====
// rate selector, memory self-test and identification register bank
`timescale 1ns/1ps
// Summary of operation
// - thirty-two output rate selectors sit at consecutive word addresses 012d..014c.
// - bits 1:0 of each selector pick 2, 4, 8 or 16 Mbps for that stream.
// - fast mode overrides selectors: streams 0-15 at 32 Mbps, 16-31 unused.
// - self-test mode is active while bit 12 of the self-test register is high.
// - a rising start bit 11, 8, 5 or 2 launches the matching memory test.
// - completion bits 10, 7, 4, 1 go high when their test ends and are polled.
// - after completion bits 9, 6, 3, 0 report pass high or fail low.
// - the identification register at 3fff holds revision 7:4 and part code 2:0.
// - identification bits 15:8 and bit 3 read as zero.
// - selectors and the self-test register reset to zero.
module rbir_regs #(
   parameter logic [3:0] silicon_revision = 4'h5, // arbitrary value
   parameter logic [2:0] part_code        = 3'h6, // arbitrary value
   parameter int         test_len         = rbir_pkg::test_cycles
) (
   input  wire logic        mclk,
   input  wire logic        srst,
   input  wire logic        cs,
   input  wire logic        wr,
   input  wire logic        rd,
   input  wire logic [13:0] addr,
   input  wire logic [15:0] wdata,
   input  wire logic        backplane_fast_mode,
   input  wire logic [3:0]  mem_fail,
   output logic      [15:0] rdata,
   output logic             rvalid,
   output logic             self_test_enable,
   output logic      [95:0] stream_speed
);
   // notes for integration:
   // - the speed codes lag a selector write by two cycles: one to store
   //   the field, one to register the code for the datapath.
   // - a test starts only when bit 12 was already high before the write
   //   that raises a start bit; one write cannot arm and launch at once.
   // - a start bit that is already high must be written low before it
   //   can launch again; a completed test may be relaunched this way.
   // - clearing bit 12 aborts every running test and clears all status.
   // - the identity fields are parameters; their defaults are arbitrary
   //   and carry no meaning.
   // - mem_fail is sampled every running cycle; one high cycle fails it.

   // ==========================================================
   // elaboration checks: the run counter is 16 bits wide, and a test
   // shorter than two cycles is refused, though one cycle would still sample once
   if (test_len < 2 || test_len > 65535) begin : g_bad_len
      $error("test_len out of range");
   end
   if (rbir_pkg::fast_streams > rbir_pkg::num_streams) begin : g_bad_fast
      $error("fast stream count above stream count");
   end

   // ==========================================================
   // address decode
   function automatic logic is_rate(input logic [13:0] a);
      return a >= rbir_pkg::rate_base_addr && a <= rbir_pkg::rate_last_addr;
   endfunction

   logic [1:0]  out_rate_field [rbir_pkg::num_streams];
   logic [4:0]  rate_idx;
   logic        wr_rate;
   logic        wr_bist;
   // the index is the offset from the first selector; it only means
   // something while is_rate() holds, so every user qualifies it
   assign rate_idx = 5'(addr - rbir_pkg::rate_base_addr);
   assign wr_rate  = cs && wr && is_rate(addr);
   assign wr_bist  = cs && wr && (addr == rbir_pkg::bist_addr);

   // ==========================================================
   // rate selectors; only bits 1:0 are stored, reserved bits drop out
   // (reserved bits cost no flops and always read back as zero)
   always_ff @(posedge mclk) begin
      for (int i = 0; i < rbir_pkg::num_streams; i++) begin
         if (srst)
            out_rate_field[i] <= rbir_pkg::rate_reset[1:0];
         else if (wr_rate && rate_idx == 5'(i))
            out_rate_field[i] <= wdata[rbir_pkg::rate_msb:rbir_pkg::rate_lsb];
      end
   end

   // ==========================================================
   // per-stream speed codes for the datapath, registered
   // the override is applied here rather than in the selectors, so the
   // stored codes survive a trip through fast mode unchanged
   genvar g;
   generate
      for (g = 0; g < rbir_pkg::num_streams; g++) begin : g_spd
         always_ff @(posedge mclk) begin
            if (srst)
               stream_speed[3*g +: 3] <= rbir_pkg::spd_2m;
            else if (backplane_fast_mode)
               stream_speed[3*g +: 3] <= (g < rbir_pkg::fast_streams) ?
                  rbir_pkg::spd_32m : rbir_pkg::spd_off;
            else
               stream_speed[3*g +: 3] <= {1'b0, out_rate_field[g]};
         end
      end
   endgenerate

   // ==========================================================
   // self-test control: enable, start bits and the per-memory engines
   logic [3:0] start_q;
   logic [3:0] start_new;
   logic [3:0] done_q;
   logic [3:0] pass_q;
   assign start_new = {wdata[rbir_pkg::start_bp_data],
                       wdata[rbir_pkg::start_lc_data],
                       wdata[rbir_pkg::start_bp_conn],
                       wdata[rbir_pkg::start_lc_conn]};

   // reset value of the enable taken from the packed reset word, so the
   // two cannot drift apart
   function automatic logic bist_reset_en();
      return rbir_pkg::bist_reset[rbir_pkg::bist_en_bit];
   endfunction

   // enable and stored start bits; start bits written with bit 12 low
   // are dropped, so leaving test mode also forgets old start levels
   always_ff @(posedge mclk) begin
      if (srst) begin
         self_test_enable <= bist_reset_en();
         start_q          <= 4'h0;
      end else if (wr_bist) begin
         self_test_enable <= wdata[rbir_pkg::bist_en_bit];
         start_q          <= wdata[rbir_pkg::bist_en_bit] ? start_new : 4'h0;
      end
   end

   // rising start edges only count in test mode, so the first 1000h write
   // arms the mode and a later write that adds a start bit launches (software ordering assumed)
   logic [3:0] launch;
   assign launch = (wr_bist && self_test_enable && wdata[rbir_pkg::bist_en_bit])
                   ? (start_new & ~start_q) : 4'h0;

   generate
      for (g = 0; g < 4; g++) begin : g_eng
         rbir_pkg::rbir_state_t st;
         logic [15:0]           cnt;
         logic                  err;
         logic                  done_r;
         logic                  pass_r;
         // one driver per status bit keeps each vector single-sourced
         assign done_q[g] = done_r;
         assign pass_q[g] = pass_r;

         // leaving test mode aborts a run and wipes its status, so a
         // half-finished result can never be read back as a verdict
         always_ff @(posedge mclk) begin
            if (srst || !self_test_enable) begin
               st     <= rbir_pkg::rbir_idle;
               cnt    <= 16'h0000;
               err    <= 1'b0;
               done_r <= 1'b0;
               pass_r <= 1'b0;
            end else begin
               case (st)
                  rbir_pkg::rbir_idle: begin
                     if (launch[g]) begin
                        st     <= rbir_pkg::rbir_run;
                        cnt    <= 16'h0000;
                        err    <= 1'b0;
                        done_r <= 1'b0;
                        pass_r <= 1'b0;
                     end
                  end
                  // a fault seen in any cycle of the run sticks to the end
                  rbir_pkg::rbir_run: begin
                     cnt <= cnt + 16'h0001;
                     if (mem_fail[g])
                        err <= 1'b1;
                     if (cnt == 16'(test_len - 1)) begin
                        st     <= rbir_pkg::rbir_done;
                        done_r <= 1'b1;
                        pass_r <= !(err || mem_fail[g]);
                     end
                  end
                  // result holds until a fresh launch or the mode is left
                  rbir_pkg::rbir_done: begin
                     if (launch[g]) begin
                        st     <= rbir_pkg::rbir_run;
                        cnt    <= 16'h0000;
                        err    <= 1'b0;
                        done_r <= 1'b0;
                        pass_r <= 1'b0;
                     end
                  end
                  default: st <= rbir_pkg::rbir_idle;
               endcase
            end
         end
      end
   endgenerate

   // ==========================================================
   // read path, one cycle after the strobe; status bits come from the
   // engines only, so writes cannot touch them
   // a read of an unmapped word answers zero rather than stale data
   logic [15:0] bist_view;
   logic [15:0] id_view;
   assign bist_view = {3'b000, self_test_enable,
                       start_q[3], done_q[3], pass_q[3],
                       start_q[2], done_q[2], pass_q[2],
                       start_q[1], done_q[1], pass_q[1],
                       start_q[0], done_q[0], pass_q[0]};
   assign id_view   = {8'h00, silicon_revision, 1'b0, part_code};

   always_ff @(posedge mclk) begin
      if (srst) begin
         rdata  <= 16'h0000;
         rvalid <= 1'b0;
      end else begin
         rvalid <= cs && rd;
         if (cs && rd) begin
            if (is_rate(addr))
               rdata <= {14'h0000, out_rate_field[rate_idx]};
            else if (addr == rbir_pkg::bist_addr)
               rdata <= bist_view;
            else if (addr == rbir_pkg::id_addr)
               rdata <= id_view;
            else
               rdata <= 16'h0000;
         end
      end
   end

   // ==========================================================
   // checks
   sequence arm_s;
      wr_bist && wdata[rbir_pkg::bist_en_bit];
   endsequence

   rate_store_a: assert property (@(posedge mclk) disable iff (srst)
      (wr_rate && rate_idx == 5'd3 && !backplane_fast_mode)
      ##1 !backplane_fast_mode |=> stream_speed[11:9] == {1'b0, $past(wdata[1:0], 2)})
      else $error("rate write not applied");
   fast_mode_a: assert property (@(posedge mclk) disable iff (srst)
      backplane_fast_mode |=> stream_speed[2:0] == rbir_pkg::spd_32m
      && stream_speed[95:93] == rbir_pkg::spd_off)
      else $error("fast mode override wrong");
   speed_map_a: assert property (@(posedge mclk) disable iff (srst)
      !backplane_fast_mode |=> stream_speed[5:3] == {1'b0, $past(out_rate_field[1])})
      else $error("speed code mismatch");
   test_mode_a: assert property (@(posedge mclk) disable iff (srst)
      arm_s |=> self_test_enable)
      else $error("test mode not entered");
   exit_clear_a: assert property (@(posedge mclk) disable iff (srst)
      !self_test_enable |=> done_q == 4'h0)
      else $error("status kept outside test mode");
   launch_run_a: assert property (@(posedge mclk) disable iff (srst)
      launch[0] && self_test_enable && g_eng[0].st == rbir_pkg::rbir_idle
      |=> g_eng[0].st == rbir_pkg::rbir_run && !done_q[0])
      else $error("launch did not start test");
   done_rise_a: assert property (@(posedge mclk) disable iff (srst)
      $rose(done_q[0]) |-> $past(g_eng[0].st) == rbir_pkg::rbir_run)
      else $error("completion without run");
   pass_only_a: assert property (@(posedge mclk) disable iff (srst)
      pass_q[1] |-> done_q[1])
      else $error("pass without completion");
   id_read_a: assert property (@(posedge mclk) disable iff (srst)
      cs && rd && addr == rbir_pkg::id_addr |=> rvalid
      && rdata == {8'h00, silicon_revision, 1'b0, part_code})
      else $error("id register read wrong");
   reset_zero_a: assert property (@(posedge mclk)
      srst |=> !self_test_enable && out_rate_field[0] == 2'b00)
      else $error("reset values wrong");

   // ==========================================================
   // further checks on selectors, reads and the self-test engines
   sequence bp_launch_s;
      wr_bist && self_test_enable && wdata[rbir_pkg::bist_en_bit]
      && wdata[rbir_pkg::start_bp_data] && !start_q[3];
   endsequence

   sequence bp_done_s;
      $rose(done_q[3]);
   endsequence

   bp_launch_a: assert property (@(posedge mclk) disable iff (srst)
      bp_launch_s |=> g_eng[3].st == rbir_pkg::rbir_run && !done_q[3])
      else $error("backplane data test not launched");
   bp_result_a: assert property (@(posedge mclk) disable iff (srst)
      bp_done_s |-> pass_q[3] == !($past(g_eng[3].err) || $past(mem_fail[3])))
      else $error("backplane data result wrong");
   status_keep_a: assert property (@(posedge mclk) disable iff (srst)
      wr_bist && wdata[rbir_pkg::bist_en_bit] && self_test_enable
      && done_q[3] && !launch[3]
      |=> done_q[3] && pass_q[3] == $past(pass_q[3]))
      else $error("status bit changed by a write");

   start_drop_a: assert property (@(posedge mclk) disable iff (srst)
      wr_bist && !wdata[rbir_pkg::bist_en_bit]
      |=> start_q == 4'h0 && !self_test_enable)
      else $error("start bits kept without test mode");
   no_launch_a: assert property (@(posedge mclk) disable iff (srst)
      wr_bist && !self_test_enable |-> launch == 4'h0)
      else $error("launch without prior arming");
   exit_pass_a: assert property (@(posedge mclk) disable iff (srst)
      !self_test_enable |=> pass_q == 4'h0)
      else $error("pass bits kept outside test mode");

   rate_hold_a: assert property (@(posedge mclk) disable iff (srst)
      !(wr_rate && rate_idx == 5'd0) |=> $stable(out_rate_field[0]))
      else $error("selector changed without its write");
   top_speed_a: assert property (@(posedge mclk) disable iff (srst)
      !backplane_fast_mode
      |=> stream_speed[95:93] == {1'b0, $past(out_rate_field[31])})
      else $error("last stream speed wrong");
   unused_hi_a: assert property (@(posedge mclk) disable iff (srst)
      backplane_fast_mode |=> stream_speed[50:48] == rbir_pkg::spd_off
      && stream_speed[47:45] == rbir_pkg::spd_32m)
      else $error("fast mode split wrong");

   read_pulse_a: assert property (@(posedge mclk) disable iff (srst)
      !(cs && rd) |=> !rvalid)
      else $error("read valid without a read");
   id_zero_a: assert property (@(posedge mclk) disable iff (srst)
      cs && rd && addr == rbir_pkg::id_addr
      |=> rdata[15:8] == 8'h00 && !rdata[3])
      else $error("id reserved bits not zero");
   reset_out_a: assert property (@(posedge mclk)
      srst |=> stream_speed == 96'h0 && rdata == 16'h0000
      && !rvalid && start_q == 4'h0)
      else $error("outputs not cleared by reset");

   // independent length check on the local connection engine: count the
   // cycles it spends running and compare at completion
   logic [15:0] run_cycles_0;
   always_ff @(posedge mclk) begin
      if (srst || g_eng[0].st != rbir_pkg::rbir_run)
         run_cycles_0 <= 16'h0000;
      else
         run_cycles_0 <= run_cycles_0 + 16'h0001;
   end
   run_length_a: assert property (@(posedge mclk) disable iff (srst)
      $rose(done_q[0]) |-> run_cycles_0 == 16'(test_len))
      else $error("test length wrong");
endmodule // rbir_regs

// ==== test_rbir_regs.sv ====
// self-checking bench for the rate, self-test and identification bank
`timescale 1ns/1ps
module test_rbir_regs;
   localparam int tlen = 4; // short test run keeps polling cheap
   logic        mclk;
   logic        srst;
   logic        cs;
   logic        wr;
   logic        rd;
   logic [13:0] addr;
   logic [15:0] wdata;
   logic        backplane_fast_mode;
   logic [3:0]  mem_fail;
   logic [15:0] rdata;
   logic        rvalid;
   logic        self_test_enable;
   logic [95:0] stream_speed;
   logic [15:0] got;
   logic [15:0] st;
   logic [15:0] want;
   int          n_fail;
   int          checks_done;

   // ==========================================================
   // device under test, identity values arbitrary
   rbir_regs #(
      .silicon_revision (4'h5),
      .part_code        (3'h6),
      .test_len         (tlen)
   ) i_rbir_regs (
      .mclk                (mclk),
      .srst                (srst),
      .cs                  (cs),
      .wr                  (wr),
      .rd                  (rd),
      .addr                (addr),
      .wdata               (wdata),
      .backplane_fast_mode (backplane_fast_mode),
      .mem_fail            (mem_fail),
      .rdata               (rdata),
      .rvalid              (rvalid),
      .self_test_enable    (self_test_enable),
      .stream_speed        (stream_speed)
   );

   // 200 MHz clock
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // ==========================================================
   // access tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one-cycle strobe, launched just after an edge
   task automatic wr_reg(input logic [13:0] a, input logic [15:0] d);
      @(posedge mclk);
      #1;
      cs = 1'b1;
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(posedge mclk);
      #1;
      cs = 1'b0;
      wr = 1'b0;
   endtask

   // rvalid is a single-cycle pulse, so it is sampled right here
   task automatic rd_reg(input logic [13:0] a, output logic [15:0] d);
      @(posedge mclk);
      #1;
      cs = 1'b1;
      rd = 1'b1;
      addr = a;
      @(posedge mclk);
      #1;
      cs = 1'b0;
      rd = 1'b0;
      chk({15'h0000, rvalid}, 16'h0001);
      d = rdata;
   endtask

   task automatic rd_chk(input logic [13:0] a, input logic [15:0] exp);
      rd_reg(a, got);
      chk(got, exp);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // bounded poll of a completion bit; a hung test ends the run
   task automatic poll(input logic [15:0] mask);
      int tries;
      tries = 0;
      got = 16'h0000;
      while (((got & mask) == 16'h0000) && tries < 20) begin
         rd_reg(14'h014d, got);
         tries++;
      end
      if ((got & mask) == 16'h0000) begin
         n_fail++;
         $display("ERROR t=%0t self test never completed", $time);
         tally_and_finish();
      end
   endtask

   // ==========================================================
   // main sequence
   initial begin
      srst = 1'b1;
      cs = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 14'h0000;
      wdata = 16'h0000;
      backplane_fast_mode = 1'b0;
      mem_fail = 4'h0;
      n_fail = 0;
      checks_done = 0;
      repeat (20) @(posedge mclk);
      #1;
      srst = 1'b0;
      chk(stream_speed[15:0], 16'h0000);
      chk({15'h0000, self_test_enable}, 16'h0000);
      rd_chk(14'h012d, 16'h0000);
      rd_chk(14'h014d, 16'h0000);
      // every selector gets a code, cycling through all four rates
      for (int n = 0; n < 32; n++) begin
         wr_reg(14'h012d + 14'(n), 16'(n % 4));
      end
      repeat (3) @(posedge mclk);
      #1;
      for (int n = 0; n < 32; n++) begin
         chk(16'(stream_speed[3*n +: 3]), 16'(n % 4));
         rd_chk(14'h012d + 14'(n), 16'(n % 4));
      end
      // fast mode overrides every selector
      backplane_fast_mode = 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      for (int n = 0; n < 32; n++) begin
         chk(16'(stream_speed[3*n +: 3]), (n < 16) ? 16'h4 : 16'h7);
      end
      backplane_fast_mode = 1'b0;
      // unmapped places and the read-only identity word
      wr_reg(14'h014e, 16'hffff);
      rd_chk(14'h014e, 16'h0000);
      rd_chk(14'h012c, 16'h0000);
      rd_chk(14'h3fff, 16'h0056);
      wr_reg(14'h3fff, 16'hffff);
      rd_chk(14'h3fff, 16'h0056);
      // each memory in turn, odd ones with an injected fault
      for (int k = 0; k < 4; k++) begin
         st = 16'h0800 >> (3 * k);
         want = 16'h1000 | st | (st >> 1) | ((k % 2 == 0) ? (st >> 2) : 16'h0);
         mem_fail = (k % 2 == 1) ? (4'h8 >> k) : 4'h0;
         wr_reg(14'h014d, 16'h1000);
         chk({15'h0000, self_test_enable}, 16'h0001);
         rd_chk(14'h014d, 16'h1000);
         wr_reg(14'h014d, 16'h1000 | st);
         poll(st >> 1);
         rd_chk(14'h014d, want);
         wr_reg(14'h014d, want ^ ((st >> 1) | (st >> 2)));
         rd_chk(14'h014d, want);
         wr_reg(14'h014d, 16'h0000);
         chk({15'h0000, self_test_enable}, 16'h0000);
         mem_fail = 4'h0;
      end
      tally_and_finish();
   end
endmodule // test_rbir_regs
